// [scs_clock_source_select.sv]
/*
 * System clock source selector: mode decode, pin routing, clock tick selection,
 * start-up wait sequencing and an AHB-Lite register slave.
 * Assumes one 20 MHz clock, synchronous active-low reset, a single AHB-Lite
 * master, and power-up, sleep and wake signals from logic on the same clock.
 */
// Contract
// - Eight clock modes come from a three-bit configuration field.
// - Internal modes give 8 MHz directly or 4 MHz through a postscaler.
// - Crystal modes wait 1024 crystal input oscillations before the clock is stable.
// - Start-up wait begins after power-up delay if enabled, and on every wake.
// - Program counter is held while the start-up wait runs.
// - External clock mode skips the start-up wait entirely.
// - External clock mode clocks from first pin; second pin is general I/O.
// - Stopped external clock freezes all state; restart resumes unchanged.
// - Resistor-capacitor mode drives second pin with oscillator frequency over four.
// - Resistor-capacitor pin I/O variant frees the second pin as general I/O.
// - Internal mode with output drives clock over four, frees first pin.
// - Internal mode without output frees both oscillator pins.
// - Crystal modes pick lowest, intermediate or highest amplifier gain.
// - A configuration bit picks 4 MHz or 8 MHz internal clock.
`timescale 1ns/100ps
`include "scs_map.svh"
module scs_clock_source_select
    import scs_pkg::*;
#(
    parameter scs_mode_e MODE_MAP [0:7] = '{SCS_LOW_GAIN, SCS_MED_GAIN, SCS_HIGH_GAIN, SCS_EXT_CLOCK,
        SCS_INT_BOTH_FREE, SCS_INT_WITH_OUT, SCS_RC_PIN_IO, SCS_RC_DIVIDED_CLOCK_OUTPUT}
)(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Power and sleep events from the core.
    input wire logic powerUpDelayDone,
    input wire logic sleepRequest,
    input wire logic wakeEvent,
    // Internal oscillator raw output, 8 MHz, asynchronous.
    input wire logic intOscIn,
    // First oscillator pin, crystal input side.
    input wire logic crystalInPinIn,
    output logic crystalInPinOut,
    output logic crystalInPinOeN,
    // Second oscillator pin, crystal output side.
    input wire logic crystalOutPinIn,
    output logic crystalOutPinOut,
    output logic crystalOutPinOeN,
    // Amplifier and system clock controls.
    output logic ampEnable,
    output logic [1:0] ampGain,
    output logic sysClockTick,
    output logic holdPc
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [2:0] pinRaw;
    logic [2:0] syncA_reg, syncB_reg, syncC_reg;
    logic [2:0] pinEdge;

    assign pinRaw = {intOscIn, crystalOutPinIn, crystalInPinIn};

    // Two flip-flops per input, then a third for rising-edge detection.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    syncA_reg[gi] <= 1'b0;
                    syncB_reg[gi] <= 1'b0;
                    syncC_reg[gi] <= 1'b0;
                end else begin
                    syncA_reg[gi] <= pinRaw[gi];
                    syncB_reg[gi] <= syncA_reg[gi];
                    syncC_reg[gi] <= syncB_reg[gi];
                end
            end
            assign pinEdge[gi] = syncB_reg[gi] & ~syncC_reg[gi];
        end
    endgenerate

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [4:0] config_reg, config_next;
    logic [3:0] pinio_reg, pinio_next;
    logic pending_reg, pending_next;
    logic pendWrite_reg, pendWrite_next;
    logic [7:0] pendAddr_reg, pendAddr_next;
    logic hreadyout_reg, hreadyout_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [31:0] statusWord;
    scs_state_e state_reg, state_next;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    scs_mode_e mode;
    logic speed8;
    logic pwrDlyEnable;
    logic isCrystal, isInternal, isExtClock, driveClkOut, pin0Free, pin1Free;
    logic [1:0] gainSel;

    assign mode = MODE_MAP[config_reg[`SCS_CFG_MODE_MSB:`SCS_CFG_MODE_LSB]];
    assign speed8 = config_reg[`SCS_CFG_SPEED_BIT];
    assign pwrDlyEnable = config_reg[`SCS_CFG_PWRDLY_BIT];

    // Per-mode source, pin use and amplifier gain.
    always_comb begin
        isCrystal = 1'b0;
        isInternal = 1'b0;
        isExtClock = 1'b0;
        driveClkOut = 1'b0;
        pin0Free = 1'b0;
        pin1Free = 1'b0;
        gainSel = 2'h0;
        case (mode)
            SCS_LOW_GAIN: begin
                isCrystal = 1'b1;
                gainSel = 2'h1;
            end
            SCS_MED_GAIN: begin
                isCrystal = 1'b1;
                gainSel = 2'h2;
            end
            SCS_HIGH_GAIN: begin
                isCrystal = 1'b1;
                gainSel = 2'h3;
            end
            SCS_EXT_CLOCK: begin
                isExtClock = 1'b1;
                pin1Free = 1'b1;
            end
            SCS_INT_BOTH_FREE: begin
                isInternal = 1'b1;
                pin0Free = 1'b1;
                pin1Free = 1'b1;
            end
            SCS_INT_WITH_OUT: begin
                isInternal = 1'b1;
                pin0Free = 1'b1;
                driveClkOut = 1'b1;
            end
            SCS_RC_PIN_IO: begin
                pin1Free = 1'b1;
            end
            SCS_RC_DIVIDED_CLOCK_OUTPUT: begin
                driveClkOut = 1'b1;
            end
            default: begin
                isExtClock = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Clock tick selection and dividers
    // ****************************************************************
    logic postTick;
    logic fosc4Level;
    logic sysTickSel;

    // Postscaler turns 8 MHz internal ticks into 4 MHz ticks.
    scs_tick_halver u_postscaler (
        .clk(clk),
        .reset_n(reset_n),
        .tickIn(pinEdge[2]),
        .halfTick(postTick),
        .quarterLevel()
    );

    // Internal ticks by speed bit; external modes tick only on first-pin edges, so a stopped clock freezes.
    assign sysTickSel = isInternal ? (speed8 ? pinEdge[2] : postTick) : pinEdge[0];

    // Oscillator frequency over four for the clock output pin.
    scs_tick_halver u_divided_clock_output_div (
        .clk(clk),
        .reset_n(reset_n),
        .tickIn(sysTickSel),
        .halfTick(),
        .quarterLevel(fosc4Level)
    );

    // ****************************************************************
    // Start-up sequencer
    // ****************************************************************
    logic cntClear, cntTick, cntDone;
    logic [10:0] cntTarget;

    // Counter runs on crystal edges in count state and on clk cycles in warm state.
    assign cntClear = (state_reg != state_next);
    assign cntTick = (state_reg == SCS_ST_COUNT) ? pinEdge[0] : (state_reg == SCS_ST_WARM);
    assign cntTarget = (state_reg == SCS_ST_COUNT) ? `SCS_OST_COUNT : `SCS_WARM_COUNT;

    scs_startup_counter u_counter (
        .clk(clk),
        .reset_n(reset_n),
        .clear(cntClear),
        .tick(cntTick),
        .target(cntTarget),
        .done(cntDone)
    );

    // Next state: power-up, optional wait, ready, sleep and wake.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SCS_ST_POWER: begin
                if (!pwrDlyEnable || powerUpDelayDone) begin
                    if (isCrystal) begin
                        state_next = SCS_ST_COUNT;
                    end else if (isInternal) begin
                        state_next = SCS_ST_WARM;
                    end else begin
                        state_next = SCS_ST_READY;
                    end
                end
            end
            SCS_ST_COUNT: begin
                if (cntDone) begin
                    state_next = SCS_ST_READY;
                end
            end
            SCS_ST_WARM: begin
                if (cntDone) begin
                    state_next = SCS_ST_READY;
                end
            end
            SCS_ST_READY: begin
                if (sleepRequest) begin
                    state_next = SCS_ST_SLEEP;
                end
            end
            SCS_ST_SLEEP: begin
                if (wakeEvent) begin
                    if (isCrystal) begin
                        state_next = SCS_ST_COUNT;
                    end else if (isInternal) begin
                        state_next = SCS_ST_WARM;
                    end else begin
                        state_next = SCS_ST_READY;
                    end
                end
            end
            default: begin
                state_next = SCS_ST_POWER;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= SCS_ST_POWER;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    assign statusWord = {26'h000_0000, isInternal, mode, (state_reg == SCS_ST_READY), holdPc};

    // Address phase is captured, then one wait cycle performs the access and registers read data.
    always_comb begin
        pending_next = 1'b0;
        pendWrite_next = pendWrite_reg;
        pendAddr_next = pendAddr_reg;
        hreadyout_next = 1'b1;
        hrdata_next = hrdata_reg;
        config_next = config_reg;
        pinio_next = pinio_reg;
        if (pending_reg) begin
            if (pendWrite_reg) begin
                case (pendAddr_reg)
                    `SCS_OFF_CONFIG: config_next = hwdata[4:0];
                    `SCS_OFF_PINIO: pinio_next = hwdata[3:0];
                    default: config_next = config_reg;
                endcase
            end else begin
                case (pendAddr_reg)
                    `SCS_OFF_CONFIG: hrdata_next = {27'h000_0000, config_reg};
                    `SCS_OFF_PINIO: hrdata_next = {26'h000_0000, syncB_reg[1:0], pinio_reg};
                    `SCS_OFF_STATUS: hrdata_next = statusWord;
                    default: hrdata_next = 32'h0000_0000;
                endcase
            end
        end else if (hsel && htrans[1] && hready) begin
            pending_next = 1'b1;
            pendWrite_next = hwrite;
            pendAddr_next = {haddr[7:2], 2'h0};
            hreadyout_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pending_reg <= 1'b0;
            pendWrite_reg <= 1'b0;
            pendAddr_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
            config_reg <= `SCS_CFG_RESET;
            pinio_reg <= `SCS_PIN_RESET;
        end else begin
            pending_reg <= pending_next;
            pendWrite_reg <= pendWrite_next;
            pendAddr_reg <= pendAddr_next;
            hreadyout_reg <= hreadyout_next;
            hrdata_reg <= hrdata_next;
            config_reg <= config_next;
            pinio_reg <= pinio_next;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    logic pin0Out_reg, pin0Out_next, pin0OeN_reg, pin0OeN_next;
    logic pin1Out_reg, pin1Out_next, pin1OeN_reg, pin1OeN_next;
    logic ampEn_reg, ampEn_next, sysTick_reg, sysTick_next, holdPc_reg, holdPc_next;
    logic [1:0] gain_reg, gain_next;

    // Pin routing, amplifier, system tick and program counter hold.
    always_comb begin
        pin0Out_next = pinio_reg[`SCS_PIN_LAT0_BIT];
        pin0OeN_next = ~(pin0Free & ~pinio_reg[`SCS_PIN_DIR0_BIT]);
        if (driveClkOut) begin
            pin1Out_next = fosc4Level;
            pin1OeN_next = 1'b0;
        end else begin
            pin1Out_next = pinio_reg[`SCS_PIN_LAT1_BIT];
            pin1OeN_next = ~(pin1Free & ~pinio_reg[`SCS_PIN_DIR1_BIT]);
        end
        ampEn_next = isCrystal;
        gain_next = gainSel;
        sysTick_next = sysTickSel & ~isExtClock | sysTickSel & isExtClock;
        holdPc_next = (state_next != SCS_ST_READY);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin0Out_reg <= 1'b0;
            pin0OeN_reg <= 1'b1;
            pin1Out_reg <= 1'b0;
            pin1OeN_reg <= 1'b1;
            ampEn_reg <= 1'b0;
            gain_reg <= 2'h0;
            sysTick_reg <= 1'b0;
            holdPc_reg <= 1'b1;
        end else begin
            pin0Out_reg <= pin0Out_next;
            pin0OeN_reg <= pin0OeN_next;
            pin1Out_reg <= pin1Out_next;
            pin1OeN_reg <= pin1OeN_next;
            ampEn_reg <= ampEn_next;
            gain_reg <= gain_next;
            sysTick_reg <= sysTick_next;
            holdPc_reg <= holdPc_next;
        end
    end

    assign crystalInPinOut = pin0Out_reg;
    assign crystalInPinOeN = pin0OeN_reg;
    assign crystalOutPinOut = pin1Out_reg;
    assign crystalOutPinOeN = pin1OeN_reg;
    assign ampEnable = ampEn_reg;
    assign ampGain = gain_reg;
    assign sysClockTick = sysTick_reg;
    assign holdPc = holdPc_reg;

endmodule

// [scs_map.svh]
/*
 * Offsets, field positions, reset values and counts of the clock source selector.
 * Assumes it is included by bare name wherever the map is needed.
 */
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCS_OFF_CONFIG 8'h00
`define SCS_OFF_PINIO 8'h04
`define SCS_OFF_STATUS 8'h08

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define SCS_CFG_MODE_LSB 0
`define SCS_CFG_MODE_MSB 2
`define SCS_CFG_SPEED_BIT 3
`define SCS_CFG_PWRDLY_BIT 4
`define SCS_CFG_RESET 5'h10

// ****************************************************************
// Pin register fields
// ****************************************************************
`define SCS_PIN_LAT0_BIT 0
`define SCS_PIN_LAT1_BIT 1
`define SCS_PIN_DIR0_BIT 2
`define SCS_PIN_DIR1_BIT 3
`define SCS_PIN_LVL0_BIT 4
`define SCS_PIN_LVL1_BIT 5
`define SCS_PIN_RESET 4'hC

// ****************************************************************
// Start-up counts
// ****************************************************************
`define SCS_OST_COUNT 11'h400
`define SCS_WARM_COUNT 11'h010

`endif

// [scs_pkg.sv]
/*
 * Types of the clock source selector: clock modes and start-up states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package scs_pkg;

    // Clock source modes; codes are internal, the field decode is a parameter.
    typedef enum logic [2:0] {
        SCS_LOW_GAIN = 3'h0,
        SCS_MED_GAIN = 3'h1,
        SCS_HIGH_GAIN = 3'h2,
        SCS_EXT_CLOCK = 3'h3,
        SCS_INT_BOTH_FREE = 3'h4,
        SCS_INT_WITH_OUT = 3'h5,
        SCS_RC_PIN_IO = 3'h6,
        SCS_RC_DIVIDED_CLOCK_OUTPUT = 3'h7
    } scs_mode_e;

    // Start-up sequencer states, one-hot.
    typedef enum logic [4:0] {
        SCS_ST_POWER = 5'h01,
        SCS_ST_COUNT = 5'h02,
        SCS_ST_WARM = 5'h04,
        SCS_ST_READY = 5'h08,
        SCS_ST_SLEEP = 5'h10
    } scs_state_e;

endpackage

// [scs_tick_halver.sv]
/*
 * Halves a tick stream: a pulse on every second input tick and a level that
 * toggles on each output pulse, so the level runs at a quarter of the tick rate.
 * Assumes ticks are one-cycle pulses on clk.
 */
`timescale 1ns/100ps
module scs_tick_halver
    import scs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Tick in.
    input wire logic tickIn,
    // Halved tick and quarter-rate level.
    output logic halfTick,
    output logic quarterLevel
);

    logic phase_reg, phase_next;
    logic halfTick_reg, halfTick_next;
    logic level_reg, level_next;

    // Next phase, pulse and level.
    always_comb begin
        phase_next = phase_reg ^ tickIn;
        halfTick_next = tickIn & phase_reg;
        level_next = level_reg ^ (tickIn & phase_reg);
    end

    // Registers.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_reg <= 1'b0;
            halfTick_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            halfTick_reg <= halfTick_next;
            level_reg <= level_next;
        end
    end

    assign halfTick = halfTick_reg;
    assign quarterLevel = level_reg;

endmodule

// [scs_startup_counter.sv]
/*
 * Start-up wait counter: counts qualifying ticks up to a target and reports done.
 * Assumes clear and tick are one-cycle signals on clk.
 */
`timescale 1ns/100ps
module scs_startup_counter
    import scs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Control.
    input wire logic clear,
    input wire logic tick,
    input wire logic [10:0] target,
    // Result.
    output logic done
);

    logic [10:0] count_reg, count_next;

    // Count ticks, stop at the target, restart from zero on clear.
    always_comb begin
        if (clear) begin
            count_next = 11'h000;
        end else if (tick && count_reg != target) begin
            count_next = count_reg + 11'h001;
        end else begin
            count_next = count_reg;
        end
    end

    // Register.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_reg <= 11'h000;
        end else begin
            count_reg <= count_next;
        end
    end

    assign done = (count_reg == target);

endmodule

// [scs_osc_model.sv]
/*
 * Model of what sits at the oscillator pins: a clock source or crystal on the first
 * pin and a pull-up on the second. Assumes the bench starts and stops it.
 */
`timescale 1ns/100ps
module scs_osc_model #(
    parameter int FAST_HALF = 150,
    parameter int SLOW_HALF = 400
)(
    // Control from the bench.
    input wire logic run,
    input wire logic slow,
    // Device side of both pins.
    input wire logic inOut,
    input wire logic inOeN,
    input wire logic outOut,
    input wire logic outOeN,
    // Pin levels and count of rising edges.
    output logic inWire,
    output logic outWire,
    output int edgeCnt
);
    logic osc = 1'b0;
    // Oscillates only while run is high; a stopped source holds its last level.
    always begin
        wait (run);
        #(slow ? SLOW_HALF : FAST_HALF);
        osc = ~osc;
    end
    // Counts rising edges for exact stops.
    always @(posedge osc) edgeCnt++;
    // A driven pin shows the device; a released second pin goes to its pull-up.
    assign inWire = !inOeN ? inOut : osc;
    assign outWire = !outOeN ? outOut : 1'b1;
endmodule

// [scs_clock_source_select_assertions.sv]
/*
 * Concurrent checks on the ports of the clock source selector.
 * Assumes the bind below and the single clock domain of clk.
 */
`timescale 1ns/100ps
module scs_clock_source_select_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Bus.
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // Start-up, pins and clock.
    input wire logic sleepRequest,
    input wire logic crystalInPinOeN,
    input wire logic crystalOutPinOeN,
    input wire logic ampEnable,
    input wire logic [1:0] ampGain,
    input wire logic sysClockTick,
    input wire logic holdPc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Bus answers: one wait cycle per transfer, none unasked, always OKAY.
    a_bus_one_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
        else $error("bus wait is not one cycle");
    a_no_spurious_wait: assert property (!hreadyout |-> $past(hsel && htrans[1] && hready))
        else $error("wait without a transfer");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_rdata_holds: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed while idle");
    // Gain belongs to crystal modes, which leave both pins undriven.
    a_gain_enable: assert property (ampEnable == (ampGain != 2'b00))
        else $error("gain and enable disagree");
    a_crystal_pins: assert property (ampEnable |-> crystalInPinOeN && crystalOutPinOeN)
        else $error("pin driven in crystal mode");
    // The system tick is a single-cycle pulse.
    a_tick_single: assert property (sysClockTick |=> !sysClockTick)
        else $error("tick longer than one cycle");
    // Sleep holds the program counter; nothing else leaves the ready state.
    a_sleep_holds: assert property (sleepRequest && !holdPc |-> ##[1:2] holdPc)
        else $error("sleep did not hold");
    a_ready_stays: assert property (!holdPc && !sleepRequest |=> !holdPc)
        else $error("hold without sleep");
endmodule

bind scs_clock_source_select scs_clock_source_select_checker scs_clock_source_select_checker_inst (
    .clk, .reset_n, .hsel, .htrans, .hready, .hreadyout, .hrdata, .hresp, .sleepRequest,
    .crystalInPinOeN, .crystalOutPinOeN, .ampEnable, .ampGain, .sysClockTick, .holdPc
);

// [scs_clock_source_select_test.sv]
/*
 * Self-checking bench of the clock source selector: registers over AHB-Lite,
 * start-up wait, pin routing and tick rates. Assumes the pin model beside it.
 */
`timescale 1ns/100ps
module scs_clock_source_select_test;
    import scs_pkg::*;
    logic clk = 1'b0, internal_clock_with_output = 1'b0, run = 1'b0, slow = 1'b0;
    logic reset_n, hsel, hwrite, hreadyout, powerUpDelayDone, sleepRequest, wakeEvent;
    logic inWire, outWire, inOut, inOeN, outOut, outOeN, ampEnable, sysClockTick, holdPc, lastOut;
    logic [1:0] htrans, ampGain;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int edgeCnt, ticks, toggles, errorCnt, checksDone;

    // System clock and the free-running 8 MHz internal oscillator.
    initial forever #25 clk = ~clk;
    always #62.5 internal_clock_with_output = ~internal_clock_with_output;

    // Counts system ticks and second-pin toggles.
    always @(posedge clk) begin
        ticks <= ticks + (sysClockTick === 1'b1);
        toggles <= toggles + (outOut !== lastOut);
        lastOut <= outOut;
    end

    scs_clock_source_select scs_clock_source_select_inst (
        .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp(), .powerUpDelayDone, .sleepRequest, .wakeEvent, .intOscIn(internal_clock_with_output),
        .crystalInPinIn(inWire), .crystalInPinOut(inOut), .crystalInPinOeN(inOeN),
        .crystalOutPinIn(outWire), .crystalOutPinOut(outOut), .crystalOutPinOeN(outOeN),
        .ampEnable, .ampGain, .sysClockTick, .holdPc);
    scs_osc_model scs_osc_model_inst (.run, .slow, .inOut, .inOeN, .outOut, .outOeN, .inWire,
        .outWire, .edgeCnt);

    // Compares one value, reports a mismatch.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One AHB-Lite transfer, entered just after a rising edge.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= 32'(a);
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Writes the configuration and lets the pin outputs settle.
    task automatic cfg(input logic [31:0] v);
        bus(1'b1, 8'h00, v);
        repeat (3) @(posedge clk);
    endtask

    // Sleep, confirm the hold, then wake.
    task automatic sleepWake();
        sleepRequest <= 1'b1;
        @(posedge clk);
        sleepRequest <= 1'b0;
        repeat (4) @(posedge clk);
        check(holdPc, 1'b1);
        wakeEvent <= 1'b1;
        @(posedge clk);
        wakeEvent <= 1'b0;
    endtask

    // The hold must outlast 1023 crystal edges and end after the next one.
    task automatic ostRun();
        int base;
        base = edgeCnt;
        run = 1'b1;
        wait (edgeCnt == base + 1023);
        run = 1'b0;
        repeat (40) @(posedge clk);
        check(holdPc, 1'b1);
        run = 1'b1;
        wait (edgeCnt == base + 1024);
        run = 1'b0;
        repeat (40) @(posedge clk);
        check(holdPc, 1'b0);
    endtask

    // Runs the pin source for n edges; expects n system ticks.
    task automatic tickRun(input int n);
        int e, t;
        e = edgeCnt;
        t = ticks;
        run = 1'b1;
        wait (edgeCnt == e + n);
        run = 1'b0;
        repeat (40) @(posedge clk);
        check(ticks - t, n);
    endtask

    // Prints the counts and verdict, ends the run.
    task automatic stopTest();
        $display("checks %0d, mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Ends a hung run; a clean one takes about 1.2 ms.
    initial begin
        #3ms;
        errorCnt++;
        stopTest();
    end

    // Main sequence.
    initial begin
        int t, n, e;
        reset_n = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {powerUpDelayDone, sleepRequest, wakeEvent} = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check(holdPc, 1'b1);
        rdchk(8'h00, 32'h10);
        rdchk(8'h04, 32'h2C);
        rdchk(8'h0C, 32'h0);
        // Edges before the power-up delay ends must not count.
        run = 1'b1;
        wait (edgeCnt == 50);
        run = 1'b0;
        @(posedge clk);
        check(holdPc, 1'b1);
        powerUpDelayDone <= 1'b1;
        ostRun();
        rdchk(8'h08, 32'h2);
        for (int m = 0; m < 8; m++) begin
            cfg(32'(m));
            rdchk(8'h08, 32'h2 | 32'(m) << 2 | (m inside {4, 5} ? 32'h20 : 32'h0));
            check(ampGain, m < 3 ? m + 1 : 0);
        end
        cfg(32'h12);
        sleepWake();
        slow = 1'b1;
        ostRun();
        slow = 1'b0;
        // External clock: no wait, second pin free, static when stopped.
        bus(1'b1, 8'h04, 32'h3);
        cfg(32'h13);
        sleepWake();
        repeat (3) @(posedge clk);
        check(holdPc, 1'b0);
        check({inOeN, outOeN, outOut}, 3'h5);
        tickRun(20);
        repeat (100) @(posedge clk);
        tickRun(20);
        check(holdPc, 1'b0);
        // Resistor-capacitor modes.
        cfg(32'h17);
        t = toggles;
        tickRun(40);
        check(toggles - t, 20);
        check(outOeN, 1'b0);
        cfg(32'h16);
        check({outOeN, outOut}, 2'h1);
        // Internal oscillator with output at 4 and 8 MHz.
        for (int s = 0; s < 2; s++) begin
            cfg(32'h5 | 32'(s) << 3);
            e = 80 << s;
            t = ticks;
            n = toggles;
            repeat (400) @(posedge clk);
            check((ticks - t + 1 - e) inside {[0:2]}, 1'b1);
            check((toggles - n + 1 - e / 2) inside {[0:2]}, 1'b1);
            check({inOeN, outOeN, inOut}, 3'h1);
        end
        cfg(32'h4);
        check({inOeN, outOeN, inOut, outOut}, 4'h3);
        sleepWake();
        repeat (10) @(posedge clk);
        check(holdPc, 1'b1);
        repeat (10) @(posedge clk);
        check(holdPc, 1'b0);
        stopTest();
    end
endmodule
